/* File: hdl/adc_out_pkg.sv */
// shared constants and types for the converter output control block
package adc_out_pkg;
   localparam int unsigned DATA_W        = 14;
   localparam int unsigned PIPE_STAGES   = 6;
   localparam int unsigned LOCK_CYCLES   = 100;
   localparam int unsigned NAP_CYCLES    = 100;
   localparam int unsigned CNT_W         = 8;
   // mode strap levels, two-bit quantised code
   localparam logic [1:0] MODE_GND       = 2'h0;
   localparam logic [1:0] MODE_THIRD     = 2'h1;
   localparam logic [1:0] MODE_TWO_THIRD = 2'h2;
   localparam logic [1:0] MODE_VDD       = 2'h3;
   // register offsets of the plain register port
   localparam logic [3:0] REG_STATUS     = 4'h0;
   localparam logic [3:0] REG_LAST_WORD  = 4'h4;
   localparam logic [3:0] REG_CTRL       = 4'h8;
   localparam logic       CTRL_RST_VAL   = 1'b0;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              overrange;
   } sample_s;

   typedef enum logic [3:0] {
      ST_OFF    = 4'b0001,
      ST_LOCK   = 4'b0010,
      ST_RUN    = 4'b0100,
      ST_LOW_PW = 4'b1000
   } pw_state_e;
endpackage

/* File: hdl/adc_parallel_output_ctrl.sv */
// output control of the pipelined sampling converter
//
// Summary of operation
// - mode strap at ground or one third gives straight binary words.
// - mode strap at two thirds or full supply gives two's complement words.
// - the duty stabilizer is on only for the two middle strap levels.
// - with the stabilizer on, sampling is on the rising edge and the internal duty is fixed.
// - after a long clock stop the loop needs about one hundred cycles; words are not valid then.
// - the overrange flag is high when the sample lies beyond the convertible range.
// - while the active-low output enable is high, all data outputs and the flag float.
// - each sample's result is flagged by data_valid seven cycles after it is taken.
// - power-down high gives one low-power state whatever the output enable, outputs float, recovery 100 cycles.
`timescale 1ns/10ps
`default_nettype none
module adc_parallel_output_ctrl
   import adc_out_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rstn,
   // strap and control pins
   input  wire logic [1:0]        mode_pin,
   input  wire logic              output_enable_n,
   input  wire logic              power_down_pin,
   input  wire logic              clock_active,
   // core sample input, one per sample strobe
   input  wire logic              sample_strobe,
   input  wire logic signed [DATA_W:0] sample_raw,
   // parallel output pins
   output logic [DATA_W-1:0]      data_out,
   output logic [DATA_W-1:0]      data_oe,
   output logic                   overrange_flag,
   output logic                   overrange_oe,
   output logic                   data_valid,
   input  wire logic              capture_ready,
   // register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers, two flops per pin, reset to outputs disabled
   localparam int unsigned       SYNC_W   = 5;
   localparam logic [SYNC_W-1:0] SYNC_RST = 5'h04;
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] pin_sync;
   logic [1:0]        mode_s;
   logic              oe_n_s, pd_s, clk_act_s;

   assign pin_raw = {clock_active, power_down_pin, output_enable_n, mode_pin};

   for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
      logic s1_r, s1_nxt, s2_r, s2_nxt;

      always_comb begin
         s1_nxt = pin_raw[g];
         s2_nxt = s1_r;
      end

      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            s1_r <= SYNC_RST[g];
            s2_r <= SYNC_RST[g];
         end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
         end
      end

      assign pin_sync[g] = s2_r;
   end

   assign mode_s    = pin_sync[1:0];
   assign oe_n_s    = pin_sync[2];
   assign pd_s      = pin_sync[3];
   assign clk_act_s = pin_sync[4];

   ////////////////////////////////////////////////////////////////////
   // strap decode
   function automatic logic is_twos(input logic [1:0] m);
      return (m == MODE_TWO_THIRD) || (m == MODE_VDD);
   endfunction

   function automatic logic is_stab(input logic [1:0] m);
      return (m == MODE_THIRD) || (m == MODE_TWO_THIRD);
   endfunction

   function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] off);
      return wr && (a == off);
   endfunction

   logic twos_fmt, stab_on;
   assign twos_fmt = is_twos(mode_s);
   assign stab_on  = is_stab(mode_s);

   ////////////////////////////////////////////////////////////////////
   // input coding and overrange
   localparam logic signed [DATA_W:0] FS_MAX = (DATA_W+1)'(2**(DATA_W-1) - 1);
   localparam logic signed [DATA_W:0] FS_MIN = -(DATA_W+1)'(2**(DATA_W-1));
   sample_s conv;
   logic    over, under;
   logic [DATA_W-1:0] clipped;

   always_comb begin
      over    = sample_raw > FS_MAX;
      under   = sample_raw < FS_MIN;
      clipped = sample_raw[DATA_W-1:0];
      if (over) begin
         clipped = FS_MAX[DATA_W-1:0];
      end else if (under) begin
         clipped = FS_MIN[DATA_W-1:0];
      end
      conv.overrange = over || under;
      conv.data = twos_fmt ? clipped : {~clipped[DATA_W-1], clipped[DATA_W-2:0]};
   end

   ////////////////////////////////////////////////////////////////////
   // power and lock state
   pw_state_e         st_r, st_nxt;
   logic [CNT_W-1:0]  cnt_r, cnt_nxt;
   logic              ctrl_hold_r, ctrl_hold_nxt;

   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         ST_OFF: begin
            if (pd_s) begin
               st_nxt = ST_LOW_PW;
            end else if (clk_act_s) begin
               st_nxt  = ST_LOCK;
               cnt_nxt = stab_on ? CNT_W'(LOCK_CYCLES) : CNT_W'(0);
            end
         end
         ST_LOCK: begin
            if (pd_s) begin
               st_nxt = ST_LOW_PW;
            end else if (!clk_act_s) begin
               st_nxt = ST_OFF;
            end else if (cnt_r == '0) begin
               st_nxt = ST_RUN;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_RUN: begin
            if (pd_s) begin
               st_nxt = ST_LOW_PW;
            end else if (!clk_act_s) begin
               st_nxt = ST_OFF;
            end
         end
         ST_LOW_PW: begin
            if (!pd_s) begin
               st_nxt  = ST_LOCK;
               cnt_nxt = CNT_W'(NAP_CYCLES);
            end
         end
         default: begin
            st_nxt  = ST_OFF;
            cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_r        <= ST_OFF;
         cnt_r       <= '0;
      end else begin
         st_r        <= st_nxt;
         cnt_r       <= cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pipeline and output buffer
   logic    pipe_vld, buf_ready, out_vld;
   sample_s pipe_out, buf_out;
   logic    take;
   logic    pop_out;

   assign take    = sample_strobe && clk_act_s && (st_r != ST_LOW_PW);
   assign pop_out = data_valid && capture_ready;

   sample_pipe #(
      .DEPTH (PIPE_STAGES)
   ) u_pipe (
      .mclk       (mclk),
      .rstn       (rstn),
      .in_valid   (take),
      .in_sample  (conv),
      .out_valid  (pipe_vld),
      .out_sample (pipe_out)
   );

   // words leaving the pipe outside RUN are discarded
   skid_buf u_buf (
      .mclk    (mclk),
      .rstn    (rstn),
      .s_valid (pipe_vld && (st_r == ST_RUN)),
      .s_ready (buf_ready),
      .s_data  (pipe_out),
      .m_valid (out_vld),
      .m_ready (pop_out),
      .m_data  (buf_out)
   );

   sample_s out_r, out_nxt;
   logic    drop_r, drop_nxt;
   logic    drive;

   always_comb begin
      out_nxt  = out_r;
      drop_nxt = drop_r;
      if (pop_out) begin
         out_nxt = buf_out;
      end
      // a clear and a new drop in one cycle leave the flag set
      if (wr_hit(reg_wr, reg_addr, REG_STATUS)) begin
         drop_nxt = 1'b0;
      end
      if (pipe_vld && (st_r == ST_RUN) && !buf_ready) begin
         drop_nxt = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         out_r  <= '0;
         drop_r <= 1'b0;
      end else begin
         out_r  <= out_nxt;
         drop_r <= drop_nxt;
      end
   end

   assign drive          = !oe_n_s && (st_r != ST_LOW_PW);
   assign data_out       = out_r.data;
   assign overrange_flag = out_r.overrange;
   assign data_oe        = {DATA_W{drive}};
   assign overrange_oe   = drive;
   assign data_valid     = out_vld && drive && !ctrl_hold_r && (st_r == ST_RUN);

   ////////////////////////////////////////////////////////////////////
   // control register
   always_comb begin
      ctrl_hold_nxt = ctrl_hold_r;
      if (wr_hit(reg_wr, reg_addr, REG_CTRL)) begin
         ctrl_hold_nxt = reg_wdata[0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_hold_r <= CTRL_RST_VAL;
      end else begin
         ctrl_hold_r <= ctrl_hold_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register port, read data stand one cycle after the strobe
   logic [31:0] rdata_r, rdata_nxt;

   always_comb begin
      rdata_nxt = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            REG_STATUS: begin
               rdata_nxt = {23'h0, drop_r, st_r, stab_on, twos_fmt, pd_s, oe_n_s};
            end
            REG_LAST_WORD: begin
               rdata_nxt = {17'h0, out_r.overrange, out_r.data};
            end
            REG_CTRL: begin
               rdata_nxt = {31'h0, ctrl_hold_r};
            end
            default: begin
               rdata_nxt = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 32'h0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

/* File: hdl/sample_pipe.sv */
// six stage sample delay line carrying word and overrange flag
`timescale 1ns/10ps
`default_nettype none
module sample_pipe
   import adc_out_pkg::*;
#(
   parameter int unsigned DEPTH = PIPE_STAGES
) (
   // clock and reset
   input  wire logic    mclk,
   input  wire logic    rstn,
   // stream
   input  wire logic    in_valid,
   input  wire sample_s in_sample,
   output logic         out_valid,
   output sample_s      out_sample
);
   sample_s    stage_r [DEPTH];
   sample_s    stage_nxt [DEPTH];
   logic [DEPTH-1:0] vld_r;
   logic [DEPTH-1:0] vld_nxt;

   always_comb begin
      stage_nxt[0] = in_sample;
      vld_nxt[0]   = in_valid;
      for (int i = 1; i < DEPTH; i++) begin
         stage_nxt[i] = stage_r[i-1];
         vld_nxt[i]   = vld_r[i-1];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            stage_r[i] <= '0;
         end
         vld_r <= '0;
      end else begin
         stage_r <= stage_nxt;
         vld_r   <= vld_nxt;
      end
   end

   assign out_valid  = vld_r[DEPTH-1];
   assign out_sample = stage_r[DEPTH-1];
endmodule
`default_nettype wire

/* File: hdl/skid_buf.sv */
// two entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module skid_buf
   import adc_out_pkg::*;
(
   // clock and reset
   input  wire logic    mclk,
   input  wire logic    rstn,
   // fill side
   input  wire logic    s_valid,
   output logic         s_ready,
   input  wire sample_s s_data,
   // drain side
   output logic         m_valid,
   input  wire logic    m_ready,
   output sample_s      m_data
);
   sample_s    mem_r [2];
   sample_s    mem_nxt [2];
   logic       wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic       push, pop;

   assign s_ready = (cnt_r != 2'h2);
   assign m_valid = (cnt_r != 2'h0);
   assign m_data  = mem_r[rp_r];
   assign push    = s_valid && s_ready;
   assign pop     = m_valid && m_ready;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = s_data;
         wp_nxt        = ~wp_r;
      end
      if (pop) begin
         rp_nxt = ~rp_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wp_r     <= 1'b0;
         rp_r     <= 1'b0;
         cnt_r    <= 2'h0;
      end else begin
         mem_r <= mem_nxt;
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: verification/adc_out_props.sv */
// concurrent checks on the converter output control ports
`timescale 1ns/10ps
`default_nettype none
module adc_out_props
   import adc_out_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rstn,
   // pins
   input  wire logic [1:0]        mode_pin,
   input  wire logic              output_enable_n,
   input  wire logic              power_down_pin,
   input  wire logic              clock_active,
   input  wire logic              sample_strobe,
   input  wire logic [DATA_W-1:0] data_oe,
   input  wire logic              overrange_oe,
   input  wire logic              data_valid,
   // register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic              reg_rd,
   input  wire logic [31:0]       reg_rdata
);
   logic stab;
   assign stab = (mode_pin == MODE_THIRD) || (mode_pin == MODE_TWO_THIRD);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////
   property p_oe_off; output_enable_n [*6] |-> data_oe == '0 && !overrange_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("outputs driven while disabled");
   property p_oe_same; data_oe == {DATA_W{overrange_oe}}; endproperty
   a_oe_same: assert property (p_oe_same) else $error("flag and word enables differ");
   property p_pd_off; power_down_pin [*6] |-> !data_valid && data_oe == '0; endproperty
   a_pd_off: assert property (p_pd_off) else $error("outputs active in power down");
   property p_clk_off; !clock_active [*6] |-> !data_valid; endproperty
   a_clk_off: assert property (p_clk_off) else $error("word valid with clock stopped");
   property p_lock; $rose(clock_active) && stab |=> !data_valid [*8]; endproperty
   a_lock: assert property (p_lock) else $error("word valid during lock");
   property p_lat; $rose(data_valid) |-> $past(sample_strobe, 7); endproperty
   a_lat: assert property (p_lat) else $error("word latency wrong");
   property p_twos;
      $stable(mode_pin) [*4] ##0 (reg_rd && reg_addr == REG_STATUS) |=> reg_rdata[2] == mode_pin[1];
   endproperty
   a_twos: assert property (p_twos) else $error("format status wrong");
   property p_stab;
      $stable(mode_pin) [*4] ##0 (reg_rd && reg_addr == REG_STATUS) |=> reg_rdata[3] == stab;
   endproperty
   a_stab: assert property (p_stab) else $error("stabilizer status wrong");
endmodule
bind adc_parallel_output_ctrl adc_out_props u_props (.mclk(mclk), .rstn(rstn),
   .mode_pin(mode_pin), .output_enable_n(output_enable_n), .power_down_pin(power_down_pin),
   .clock_active(clock_active), .sample_strobe(sample_strobe), .data_oe(data_oe),
   .overrange_oe(overrange_oe), .data_valid(data_valid), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

/* File: verification/capture_sink.sv */
// capture side model registering each delivered word with its flag
`timescale 1ns/10ps
`default_nettype none
module capture_sink
   import adc_out_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rstn,
   // converter pins
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic [DATA_W-1:0] data_oe,
   input  wire logic              overrange_flag,
   input  wire logic              overrange_oe,
   input  wire logic              data_valid,
   output logic                   capture_ready,
   // bench side
   input  wire logic              stall,
   output sample_s                word,
   output logic                   got
);
   logic    pop_r;
   sample_s pin;
   // released lines show the inverse of the last captured level
   assign pin = {(data_out & data_oe) | (~word.data & ~data_oe),
                 overrange_oe ? overrange_flag : ~word.overrange};
   assign capture_ready = !stall;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pop_r <= 1'b0;
         got   <= 1'b0;
         word  <= '0;
      end else begin
         pop_r <= data_valid && capture_ready;
         got   <= pop_r;
         if (pop_r) begin
            word <= pin;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/tb_adc_parallel_output_ctrl.sv */
// self-checking bench of the converter output control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_adc_parallel_output_ctrl import adc_out_pkg::*;;
   logic                   mclk = 1'b0, rstn = 1'b0, stall = 1'b0, clock_active = 1'b1;
   logic                   output_enable_n = 1'b0, power_down_pin = 1'b0, sample_strobe = 1'b0;
   logic                   reg_wr = 1'b0, reg_rd = 1'b0, got, data_valid, capture_ready;
   logic                   overrange_flag, overrange_oe;
   logic [1:0]             mode_pin = MODE_GND;
   logic [3:0]             reg_addr = '0;
   logic [31:0]            reg_wdata = '0, reg_rdata, rd;
   logic [DATA_W-1:0]      data_out, data_oe;
   logic signed [DATA_W:0] sample_raw = '0;
   logic signed [DATA_W:0] vals[$];
   sample_s                word;
   int                     n_fail = 0, n_compared = 0;
   adc_parallel_output_ctrl u_dut (.mclk(mclk), .rstn(rstn), .mode_pin(mode_pin),
      .output_enable_n(output_enable_n), .power_down_pin(power_down_pin),
      .clock_active(clock_active), .sample_strobe(sample_strobe), .sample_raw(sample_raw),
      .data_out(data_out), .data_oe(data_oe), .overrange_flag(overrange_flag),
      .overrange_oe(overrange_oe), .data_valid(data_valid), .capture_ready(capture_ready),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   capture_sink u_sink (.mclk(mclk), .rstn(rstn), .data_out(data_out), .data_oe(data_oe),
      .overrange_flag(overrange_flag), .overrange_oe(overrange_oe), .data_valid(data_valid),
      .capture_ready(capture_ready), .stall(stall), .word(word), .got(got));
   initial forever #4 mclk = ~mclk; // even duty cycle
   ////////////////////////////////////////////////////////////////////////////
   task automatic rreg(input logic [3:0] a);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      rd = reg_rdata;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic burst();
      foreach (vals[i]) begin
         @(posedge mclk);
         sample_strobe <= 1'b1;
         sample_raw    <= vals[i];
         @(posedge mclk);
         sample_strobe <= 1'b0; // one sample every two cycles
      end
   endtask
   task automatic collect(input int n, input logic twos);
      int t;
      for (int i = 0; i < n; i++) begin
         t = 0;
         do begin @(negedge mclk); t++; end while (got !== 1'b1 && t < 200);
         `CHK(got, 1'b1)
         `CHK(word.overrange, (vals[i] > 8191 || vals[i] < -8192))
         if (vals[i] inside {[-8192:8191]})
            `CHK(word.data, vals[i][DATA_W-1:0] ^ {~twos, 13'h0})
      end
   endtask
   task automatic none(input int n);
      repeat (n) begin @(negedge mclk); `CHK(got, 1'b0) end
   endtask
   task automatic end_of_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         @(posedge mclk);
         mode_pin <= 2'(m);
         repeat (130) @(posedge mclk);
         rreg(REG_STATUS);
         `CHK(rd[2], m[1])
         `CHK(rd[3], m == 1 || m == 2)
         vals = '{-8193, -8192, 0, 8191, 8192};
         burst();
         collect(5, m[1]);
      end
   endtask
   task automatic t_buffer();
      @(posedge mclk);
      stall <= 1'b1;
      vals = '{1, 2, 3};
      burst();
      repeat (12) @(posedge mclk);
      rreg(REG_STATUS);
      `CHK(rd[8], 1'b1)
      @(posedge mclk);
      stall <= 1'b0;
      collect(2, 1'b1);
      none(20);
      wreg(REG_STATUS, 32'h100);
      rreg(REG_STATUS);
      `CHK(rd[8], 1'b0)
   endtask
   task automatic t_oe();
      @(posedge mclk);
      output_enable_n <= 1'b1; // slow toggle only
      repeat (8) @(negedge mclk);
      `CHK({data_oe, overrange_oe}, 15'h0)
      @(posedge mclk);
      output_enable_n <= 1'b0;
      repeat (8) @(negedge mclk);
      `CHK({data_oe, overrange_oe}, 15'h7fff)
   endtask
   task automatic t_pwr();
      for (int s = 0; s < 2; s++) begin
         @(posedge mclk);
         power_down_pin  <= 1'b1;
         output_enable_n <= s[0];
         repeat (8) @(negedge mclk);
         `CHK({data_oe, data_valid}, 15'h0)
         @(posedge mclk);
         power_down_pin  <= 1'b0;
         output_enable_n <= 1'b0;
         repeat (20) @(posedge mclk);
         vals = '{100};
         burst();
         none(40);
         repeat (60) @(posedge mclk);
         burst();
         collect(1, 1'b1);
      end
   endtask
   task automatic t_clock();
      @(posedge mclk);
      mode_pin     <= MODE_THIRD;
      clock_active <= 1'b0;
      repeat (20) @(posedge mclk);
      clock_active <= 1'b1;
      repeat (30) @(posedge mclk);
      vals = '{-5};
      burst();
      none(40);
      repeat (60) @(posedge mclk);
      burst();
      collect(1, 1'b0);
      rreg(REG_LAST_WORD);
      `CHK(rd[14:0], 15'h1ffb)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      rreg(REG_CTRL);
      `CHK(rd[0], CTRL_RST_VAL)
      rreg(4'hc);
      `CHK(rd, 32'h0)
      wreg(REG_CTRL, 32'h1);
      rreg(REG_CTRL);
      `CHK(rd[0], 1'b1)
      wreg(REG_CTRL, 32'h0);
      t_modes();
      t_buffer();
      t_oe();
      t_pwr();
      t_clock();
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
endmodule
`default_nettype wire
